/* File: opsfc_pkg.sv */
// shared constants for the offset-qpsk psdu spreading and fec chain
package opsfc_pkg;

  // register bus
  localparam int          AXI_AW      = 4;
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_LENGTH = 4'h4;
  localparam logic [3:0]  ADDR_STATUS = 4'h8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // control register fields
  localparam int          CTRL_START  = 0;
  localparam int          CTRL_MDSSS  = 1;
  localparam int          CTRL_FEC    = 2;
  localparam int          CTRL_DEINT  = 3;
  localparam int          CTRL_BAND   = 4;
  localparam int          CTRL_RATE   = 6;
  localparam int          CTRL_NSEL   = 8;
  localparam int          CTRL_W      = 10;
  localparam logic [9:0]  CTRL_RST    = 10'h000;

  // psdu length and status fields
  localparam int          LEN_W       = 11;
  localparam logic [10:0] LEN_RST     = 11'h000;
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_CNT    = 16;
  localparam int          CNT_W       = 16;
  localparam int          POS_W       = 16;

  // convolutional coder, tail and pad
  localparam int          OCTET_BITS  = 8;
  localparam int          TAIL_BITS   = 6;
  localparam logic [5:0]  CC_G0_TAPS  = 6'h36;
  localparam logic [5:0]  CC_G1_TAPS  = 6'h27;

  // block interleaver
  localparam int          IL_DEPTH    = 176;
  localparam int          IL_DEGREE   = 11;
  localparam int          IL_AW       = 8;

  // whitening generator
  localparam int          WH_STAGES   = 9;
  localparam logic [8:0]  WH_SEED     = 9'h001;
  localparam logic [8:0]  WH_TAPS_DEF = 9'h110;

  // hadamard (4,3) table, entry s at bits 4s+3..4s, bit c is chip c
  localparam logic [31:0] HAD_TABLE   = 32'h0a396c5f;
  // multiplex cover, row r at bits 16r+15..16r
  localparam logic [63:0] MUX_COVER_DEF = 64'h0ff0_ff00_f0f0_0000;
  localparam logic [7:0]  MUX_BASE_LEN  = 8'h10;

  // symbol levels, two's complement
  localparam logic [1:0]  SYM_POS     = 2'h1;
  localparam logic [1:0]  SYM_NEG     = 2'h3;

  typedef enum logic [1:0] {
    BAND_780  = 2'b00,
    BAND_868  = 2'b01,
    BAND_915  = 2'b10,
    BAND_2450 = 2'b11
  } opsfc_band_t;

  typedef enum logic [1:0] {
    NSEL_16  = 2'b00,
    NSEL_32  = 2'b01,
    NSEL_64  = 2'b10,
    NSEL_128 = 2'b11
  } opsfc_nsel_t;

  typedef enum logic {
    IL_FILL  = 1'b0,
    IL_DRAIN = 1'b1
  } opsfc_il_state_t;

endpackage : opsfc_pkg

/* File: opsfc_spread_fec_chain.sv */
// transmit coding chain: fec, interleaver, multiplexed spreading, whitening
// How it works
// [RULE1] unit matrix repeats n/4 times across columns
// [RULE2] xor with multiplex cover, fold rows per column
// [RULE3] wider n reuses the widened cover matrix
// [RULE4] xor chips with covering code bit zero; the code xors chip idx with covering code bit idx
// [RULE5] plain mode whitens listed band/rate pairs only
// [RULE6] no whitening otherwise, nor in multiplexed mode
// [RULE7] chip xor m-sequence element k mod 511
// [RULE8] whitening index starts zero, steps each chip
// [RULE9] seed: newest stage one, others zero
// [RULE10] chip zero is -1, chip one is +1
// [RULE11] even chips in-phase, odd chips quadrature
// [RULE12] rate half, K=7 convolutional coder
// [RULE13] six zero tail bits then zero pads
// [RULE14] pad to whole interleaver half-blocks
// [RULE15] first generator bit before second, in order
// [RULE16] interleave only with fec, else bypass
// [RULE17] 176-bit blocks, earliest block first
// [RULE18] position k moves to 16*((175-k)%11)+(175-k)/11
// [RULE19] deinterleave mode uses the inverse index map
// [RULE20] octet to three rows, lsb first, parity last
// [RULE21] rows to hadamard quads, zero gives all ones
// [RULE22] fourth row is column parity of three
// [RULE23] lowest chip index goes out first
// [RULE24] whitening taps are a parameter
// [RULE25] +1 is logic one, -1 is logic zero
// [RULE26] valid/ready between every stage
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps

module opsfc_spread_fec_chain #(
  parameter logic [8:0]   WH_TAPS   = opsfc_pkg::WH_TAPS_DEF,
  parameter logic [63:0]  MUX_COVER = opsfc_pkg::MUX_COVER_DEF,
  parameter logic [15:0]  COVER16   = 16'h0000,
  parameter logic [31:0]  COVER32   = 32'h0000_0000,
  parameter logic [63:0]  COVER64   = 64'h0000_0000_0000_0000,
  parameter logic [127:0] COVER128  = 128'h0
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [7:0]  in_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic             out_chip,
  output logic             out_quad,
  output logic [1:0]       out_sym
);

  localparam int LEN_W = opsfc_pkg::LEN_W;
  localparam int POS_W = opsfc_pkg::POS_W;
  localparam int IL_AW = opsfc_pkg::IL_AW;
  localparam int CNT_W = opsfc_pkg::CNT_W;
  localparam logic [IL_AW-1:0] IL_LAST = IL_AW'(opsfc_pkg::IL_DEPTH - 1);

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction : apply_strb

  function automatic logic [3:0] had4(input logic [2:0] sym);
    return opsfc_pkg::HAD_TABLE[{sym, 2'b00} +: 4];
  endfunction : had4

  // total data bits fed to the coder: psdu, tail, pads
  function automatic logic [POS_W-1:0] nd_bits(input logic [LEN_W-1:0] len);
    int half;
    int nb;
    half = opsfc_pkg::IL_DEPTH / 2;
    nb = (opsfc_pkg::OCTET_BITS * int'(len) + opsfc_pkg::TAIL_BITS
          + half - 1) / half;
    return POS_W'(nb * half);
  endfunction : nd_bits

  function automatic logic [IL_AW-1:0] il_perm(input logic [IL_AW-1:0] k);
    int d;
    d = opsfc_pkg::IL_DEPTH - 1 - int'(k);
    return IL_AW'((opsfc_pkg::IL_DEPTH / opsfc_pkg::IL_DEGREE)
                  * (d % opsfc_pkg::IL_DEGREE) + d / opsfc_pkg::IL_DEGREE);
  endfunction : il_perm

  function automatic logic [IL_AW-1:0] il_deint(input logic [IL_AW-1:0] i);
    int m;
    m = opsfc_pkg::IL_DEGREE * (opsfc_pkg::IL_DEPTH - 1 - int'(i));
    return IL_AW'(m - (opsfc_pkg::IL_DEPTH - 1)
                  * (m / opsfc_pkg::IL_DEPTH));
  endfunction : il_deint

  function automatic logic whiten_on(input logic [1:0] band,
                                     input logic [1:0] rate);
    case (band)
      opsfc_pkg::BAND_780:  return rate[1];
      opsfc_pkg::BAND_868:  return !rate[1];
      opsfc_pkg::BAND_915:  return rate[1];
      opsfc_pkg::BAND_2450: return &rate;
      default:              return 1'b0;
    endcase
  endfunction : whiten_on

  // one chip of an n-chip multiplexed codeword
  function automatic logic mdsss_chip(input logic [7:0] oct,
                                      input logic [6:0] idx,
                                      input logic [1:0] nsel);
    logic [3:0] h0;
    logic [3:0] h1;
    logic [3:0] h2;
    logic [3:0] col;
    logic [3:0] cov;
    logic [1:0] c;
    logic       cbar;
    logic       cc;
    h0 = had4({oct[0], oct[1], oct[2]}); // RULE20 RULE21
    h1 = had4({oct[3], oct[4], oct[5]}); // RULE20 RULE21
    h2 = had4({oct[6], oct[7], ^oct}); // RULE20 RULE21
    c = idx[1:0]; // RULE1
    col = {h0[c] ^ h1[c] ^ h2[c], h2[c], h1[c], h0[c]}; // RULE22 RULE25
    cov = {MUX_COVER[{2'd3, idx[3:0]}], MUX_COVER[{2'd2, idx[3:0]}],
           MUX_COVER[{2'd1, idx[3:0]}], MUX_COVER[{2'd0, idx[3:0]}]}; // RULE3
    cbar = ^(col ^ cov); // RULE2
    case (nsel)
      opsfc_pkg::NSEL_16:  cc = COVER16[idx[3:0]];
      opsfc_pkg::NSEL_32:  cc = COVER32[idx[4:0]];
      opsfc_pkg::NSEL_64:  cc = COVER64[idx[5:0]];
      default:             cc = COVER128[idx];
    endcase
    return cbar ^ cc; // RULE4
  endfunction : mdsss_chip

  logic [opsfc_pkg::CTRL_W-1:0] ctrl_reg;
  logic [LEN_W-1:0]             len_reg;
  logic                         start_reg;
  logic                         aw_hold_reg;
  logic [3:0]                   aw_addr_reg;
  logic                         w_hold_reg;
  logic [31:0]                  w_data_reg;
  logic [3:0]                   w_strb_reg;
  logic                         bvalid_reg;
  logic [1:0]                   bresp_reg;
  logic                         rvalid_reg;
  logic [31:0]                  rdata_reg;
  logic [1:0]                   rresp_reg;
  logic                         busy;
  logic [CNT_W-1:0]             chip_cnt_reg;
  logic [31:0]                  ctrl_word;
  logic [31:0]                  len_word;

  logic fec_en;
  logic mdsss_en;
  logic wh_en;
  logic [1:0] nsel;
  assign fec_en   = ctrl_reg[opsfc_pkg::CTRL_FEC];
  assign mdsss_en = ctrl_reg[opsfc_pkg::CTRL_MDSSS];
  assign nsel     = ctrl_reg[opsfc_pkg::CTRL_NSEL +: 2];
  assign wh_en    = !mdsss_en
                    && whiten_on(ctrl_reg[opsfc_pkg::CTRL_BAND +: 2],
                                 ctrl_reg[opsfc_pkg::CTRL_RATE +: 2]); // RULE5 RULE6
  assign ctrl_word = {{(32 - opsfc_pkg::CTRL_W){1'b0}}, ctrl_reg};
  assign len_word  = {{(32 - LEN_W){1'b0}}, len_reg};

  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready  = !w_hold_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  logic wr_go;
  assign wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= opsfc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_hold_reg)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (aw_addr_reg == opsfc_pkg::ADDR_CTRL
                        || aw_addr_reg == opsfc_pkg::ADDR_LENGTH
                        || aw_addr_reg == opsfc_pkg::ADDR_STATUS)
                       ? opsfc_pkg::RESP_OKAY : opsfc_pkg::RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // configuration is frozen while a frame is in flight
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg  <= opsfc_pkg::CTRL_RST;
      len_reg   <= opsfc_pkg::LEN_RST;
      start_reg <= 1'b0;
    end
    else
    begin
      start_reg <= 1'b0;
      if (wr_go && !busy && aw_addr_reg == opsfc_pkg::ADDR_CTRL)
      begin
        ctrl_reg  <= opsfc_pkg::CTRL_W'(apply_strb(ctrl_word, w_data_reg,
                                                   w_strb_reg));
        ctrl_reg[opsfc_pkg::CTRL_START] <= 1'b0;
        start_reg <= w_strb_reg[0] && w_data_reg[opsfc_pkg::CTRL_START];
      end
      if (wr_go && !busy && aw_addr_reg == opsfc_pkg::ADDR_LENGTH)
        len_reg <= LEN_W'(apply_strb(len_word, w_data_reg, w_strb_reg));
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= opsfc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= opsfc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        opsfc_pkg::ADDR_CTRL:   rdata_reg <= ctrl_word;
        opsfc_pkg::ADDR_LENGTH: rdata_reg <= len_word;
        opsfc_pkg::ADDR_STATUS:
          rdata_reg <= {chip_cnt_reg, 15'h0, busy};
        default:
        begin
          rdata_reg <= 32'h0;
          rresp_reg <= opsfc_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  logic             src_busy_reg;
  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] tot_reg;
  logic [LEN_W-1:0] oct_taken_reg;
  logic [7:0]       oct_reg;
  logic             oct_vld_reg;
  logic             phase_reg;
  logic [5:0]       sr_reg;
  logic [POS_W-1:0] start_tot;
  logic             in_psdu;
  logic             u_bit;
  logic             s1_valid;
  logic             s1_ready;
  logic             s1_bit;
  logic             s1_fire;
  logic             s1_step;

  assign start_tot = fec_en ? nd_bits(len_reg)
                            : POS_W'({len_reg, 3'b000}); // RULE13 RULE14
  assign in_psdu   = pos_reg < POS_W'({len_reg, 3'b000});
  assign u_bit     = in_psdu ? oct_reg[pos_reg[2:0]] : 1'b0; // RULE13
  assign in_ready  = src_busy_reg && !oct_vld_reg
                     && oct_taken_reg < len_reg; // RULE26
  assign s1_valid  = src_busy_reg && (!in_psdu || oct_vld_reg);
  assign s1_bit    = !fec_en ? u_bit
                     : phase_reg ? u_bit ^ (^(sr_reg & opsfc_pkg::CC_G1_TAPS))
                     : u_bit ^ (^(sr_reg & opsfc_pkg::CC_G0_TAPS)); // RULE12 RULE15
  assign s1_fire   = s1_valid && s1_ready;
  assign s1_step   = s1_fire && (!fec_en || phase_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_busy_reg  <= 1'b0;
      pos_reg       <= '0;
      tot_reg       <= '0;
      oct_taken_reg <= '0;
      oct_reg       <= 8'h00;
      oct_vld_reg   <= 1'b0;
      phase_reg     <= 1'b0;
      sr_reg        <= 6'h00;
    end
    else if (start_reg)
    begin
      src_busy_reg  <= start_tot != '0;
      pos_reg       <= '0;
      tot_reg       <= start_tot;
      oct_taken_reg <= '0;
      oct_vld_reg   <= 1'b0;
      phase_reg     <= 1'b0;
      sr_reg        <= 6'h00;
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        oct_reg       <= in_data;
        oct_vld_reg   <= 1'b1;
        oct_taken_reg <= oct_taken_reg + 1'b1;
      end
      if (s1_fire && fec_en && !phase_reg)
        phase_reg <= 1'b1; // RULE15
      if (s1_step)
      begin
        phase_reg <= 1'b0;
        sr_reg    <= {sr_reg[4:0], u_bit}; // RULE12
        pos_reg   <= pos_reg + 1'b1;
        if (in_psdu && pos_reg[2:0] == 3'h7)
          oct_vld_reg <= 1'b0;
        if (pos_reg + 1'b1 == tot_reg)
          src_busy_reg <= 1'b0;
      end
    end
  end

  logic                     il_mem [opsfc_pkg::IL_DEPTH];
  opsfc_pkg::opsfc_il_state_t il_state_reg;
  logic [IL_AW-1:0]         il_cnt_reg;
  logic [IL_AW-1:0]         il_wr_addr;
  logic                     s2_valid;
  logic                     s2_ready;
  logic                     s2_bit;
  logic                     s2_fire;

  assign il_wr_addr = ctrl_reg[opsfc_pkg::CTRL_DEINT] ? il_deint(il_cnt_reg)
                                                      : il_perm(il_cnt_reg); // RULE18 RULE19
  assign s1_ready = fec_en ? il_state_reg == opsfc_pkg::IL_FILL
                           : s2_ready; // RULE16
  assign s2_valid = fec_en ? il_state_reg == opsfc_pkg::IL_DRAIN
                           : s1_valid; // RULE16
  assign s2_bit   = fec_en ? il_mem[il_cnt_reg] : s1_bit;
  assign s2_fire  = s2_valid && s2_ready;

  always_ff @(posedge aclk)
  begin
    if (fec_en && s1_fire && il_state_reg == opsfc_pkg::IL_FILL)
      il_mem[il_wr_addr] <= s1_bit;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || start_reg)
    begin
      il_state_reg <= opsfc_pkg::IL_FILL;
      il_cnt_reg   <= '0;
    end
    else if (fec_en)
    begin
      case (il_state_reg)
        opsfc_pkg::IL_FILL:
          if (s1_fire)
          begin
            il_cnt_reg <= (il_cnt_reg == IL_LAST) ? '0 : il_cnt_reg + 1'b1;
            if (il_cnt_reg == IL_LAST)
              il_state_reg <= opsfc_pkg::IL_DRAIN; // RULE17
          end
        opsfc_pkg::IL_DRAIN:
          if (s2_fire)
          begin
            il_cnt_reg <= (il_cnt_reg == IL_LAST) ? '0 : il_cnt_reg + 1'b1;
            if (il_cnt_reg == IL_LAST)
              il_state_reg <= opsfc_pkg::IL_FILL; // RULE17
          end
        default:
          il_state_reg <= opsfc_pkg::IL_FILL;
      endcase
    end
  end

  logic [7:0] mx_oct_reg;
  logic [2:0] mx_bits_reg;
  logic       mx_full_reg;
  logic [6:0] mx_idx_reg;
  logic [7:0] mx_len;
  logic       s3_valid;
  logic       s3_ready;
  logic       s3_chip;
  logic       s3_fire;

  assign mx_len   = opsfc_pkg::MUX_BASE_LEN << nsel;
  assign s2_ready = mdsss_en ? !mx_full_reg : s3_ready;
  assign s3_valid = mdsss_en ? mx_full_reg : s2_valid;
  assign s3_chip  = mdsss_en ? mdsss_chip(mx_oct_reg, mx_idx_reg, nsel)
                             : s2_bit;
  assign s3_fire  = s3_valid && s3_ready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || start_reg)
    begin
      mx_oct_reg  <= 8'h00;
      mx_bits_reg <= 3'h0;
      mx_full_reg <= 1'b0;
      mx_idx_reg  <= 7'h00;
    end
    else if (mdsss_en)
    begin
      if (s2_fire)
      begin
        mx_oct_reg[mx_bits_reg] <= s2_bit;
        mx_bits_reg <= mx_bits_reg + 1'b1;
        if (mx_bits_reg == 3'h7)
          mx_full_reg <= 1'b1;
      end
      if (s3_fire)
      begin
        mx_idx_reg <= mx_idx_reg + 1'b1; // RULE23
        if ({1'b0, mx_idx_reg} == mx_len - 1'b1)
        begin
          mx_idx_reg  <= 7'h00;
          mx_full_reg <= 1'b0;
        end
      end
    end
  end

  logic [opsfc_pkg::WH_STAGES-1:0] wh_reg;
  logic                            wh_bit;
  logic                            quad_next_reg;
  logic                            out_valid_reg;
  logic                            out_chip_reg;
  logic                            out_quad_reg;
  logic [1:0]                      out_sym_reg;
  logic                            chip_w;

  assign wh_bit   = ^(wh_reg & WH_TAPS); // RULE24
  assign chip_w   = s3_chip ^ (wh_en & wh_bit); // RULE7
  assign s3_ready = !out_valid_reg || out_ready;
  assign out_valid = out_valid_reg;
  assign out_chip  = out_chip_reg;
  assign out_quad  = out_quad_reg;
  assign out_sym   = out_sym_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || start_reg)
    begin
      wh_reg        <= opsfc_pkg::WH_SEED; // RULE9
      quad_next_reg <= 1'b0;
      chip_cnt_reg  <= '0;
    end
    else if (s3_fire)
    begin
      wh_reg        <= {wh_reg[opsfc_pkg::WH_STAGES-2:0], wh_bit}; // RULE8
      quad_next_reg <= !quad_next_reg; // RULE11
      chip_cnt_reg  <= chip_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_valid_reg <= 1'b0;
      out_chip_reg  <= 1'b0;
      out_quad_reg  <= 1'b0;
      out_sym_reg   <= opsfc_pkg::SYM_NEG;
    end
    else if (s3_ready)
    begin
      out_valid_reg <= s3_valid && !start_reg;
      if (s3_fire)
      begin
        out_chip_reg <= chip_w;
        out_quad_reg <= quad_next_reg; // RULE11
        out_sym_reg  <= chip_w ? opsfc_pkg::SYM_POS
                               : opsfc_pkg::SYM_NEG; // RULE10
      end
    end
  end

  assign busy = src_busy_reg || oct_vld_reg || mx_full_reg
                || il_state_reg == opsfc_pkg::IL_DRAIN || il_cnt_reg != '0
                || mx_bits_reg != 3'h0 || out_valid_reg || start_reg;

endmodule : opsfc_spread_fec_chain

/* File: opsfc_sink.sv */
// downstream chip sink model with periodic stalls
`timescale 1ns/1ps
module opsfc_sink (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      out_ready
);
  logic [1:0] cnt_reg;
  // one stall cycle in three
  always_ff @(posedge aclk)
  begin
    cnt_reg   <= (!aresetn || cnt_reg == 2'h2) ? 2'h0 : cnt_reg + 2'h1;
    out_ready <= aresetn && cnt_reg != 2'h2;
  end
endmodule : opsfc_sink

/* File: opsfc_chk.sv */
// port assertions for the spreading and fec chain
`timescale 1ns/1ps
module opsfc_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic        out_chip,
  input wire logic        out_quad,
  input wire logic [1:0]  out_sym
);
  logic q_exp;
  always_ff @(posedge aclk)
    if (!aresetn) q_exp <= 1'b0;
    else if (out_valid && out_ready) q_exp <= !q_exp;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  chip_hold_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable({out_chip, out_quad})) else $error("chip dropped");
  sym_map_a: assert property (out_valid |-> out_sym ==
    (out_chip ? opsfc_pkg::SYM_POS : opsfc_pkg::SYM_NEG)) else $error("sym");
  quad_alt_a: assert property (out_valid |-> out_quad == q_exp)
    else $error("branch order");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read late");
  in_drop_a: assert property (in_valid && in_ready |=> !in_ready)
    else $error("octet overrun");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("wr");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 4'hc |=> s_axi_rresp == opsfc_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
  cover property (out_valid && out_ready && out_quad);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == opsfc_pkg::RESP_SLVERR);
endmodule : opsfc_chk
bind opsfc_spread_fec_chain opsfc_chk chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
  .out_ready(out_ready), .out_chip(out_chip), .out_quad(out_quad),
  .out_sym(out_sym));

/* File: tb_oqpsk_psdu_spread_fec_chain.sv */
// self-checking bench for the spreading and fec chain
`timescale 1ns/1ps
module tb_oqpsk_psdu_spread_fec_chain;
  localparam logic [63:0] MC = opsfc_pkg::MUX_COVER_DEF;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, in_valid = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, in_ready;
  logic        out_valid, out_ready, out_chip, out_quad;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_d;
  logic [1:0]  bresp, rresp, out_sym, rd_r;
  logic [7:0]  in_data = 8'h0, lf = 8'h40;
  logic [8:0]  ws;
  logic        exp_q[$];
  int          n_mismatch = 0, checked = 0, n_extra = 0, cyc = 0;
  opsfc_spread_fec_chain dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_chip(out_chip), .out_quad(out_quad),
    .out_sym(out_sym));
  opsfc_sink sink_u (.aclk(aclk), .aresetn(aresetn), .out_ready(out_ready));
  initial forever #2.5 aclk = ~aclk;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  function automatic logic wh_on(logic [1:0] b, logic [1:0] r);
    return (b == 2'h1) ? !r[1] : (b == 2'h3) ? r == 2'h3 : r[1];
  endfunction : wh_on
  task automatic wr(logic [3:0] a, logic [31:0] d);
    logic bh;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      bh = bvalid;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bh);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(logic [3:0] a);
    logic rh;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      rh = rvalid;
      rd_d = rdata;
      rd_r = rresp;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rh);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic frame(logic [9:0] c, int n);
    logic [7:0] d;
    logic       wo, s, u;
    logic [5:0] sr = 6'h00;
    logic       o[176];
    int         m;
    d = lf;
    lf = lfsr(lf);
    n_extra = 0;
    ws = 9'h001;
    wo = !c[1] && !c[2] && wh_on(c[5:4], c[7:6]);
    for (int k = 0; k < n && c[2]; k++)
    begin
      u = (k < 16) ? d[k/2] : 1'b0;
      m = c[3] ? 1925 - 11 * k - 175 * ((1925 - 11 * k) / 176)
               : 16 * ((175 - k) % 11) + (175 - k) / 11;
      o[m] = u ^ ^(sr & (k[0] ? 6'h27 : 6'h36));
      if (k[0]) sr = {sr[4:0], u};
    end
    for (int k = 0; k < n; k++)
      if (c[2]) exp_q.push_back(o[k]);
      else if (c[1])
        exp_q.push_back(^{MC[k], MC[k+16], MC[k+32], MC[k+48]});
      else
      begin
        s = ^(ws & opsfc_pkg::WH_TAPS_DEF);
        ws = {ws[7:0], s};
        exp_q.push_back(d[k] ^ (wo & s));
      end
    wr(4'h4, 32'h1);
    wr(4'h0, {22'h0, c});
    in_data <= d;
    in_valid <= 1'b1;
    do
      @(posedge aclk);
    while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    do
      rd(4'h8);
    while (rd_d[0] !== 1'b0);
    chk("chips", n, {16'h0, rd_d[31:16]});
    chk("extra", 0, n_extra);
    chk("left", 0, exp_q.size());
  endtask : frame
  always @(posedge aclk)
    if (aresetn && out_valid && out_ready)
    begin
      if (exp_q.size() == 0) n_extra++;
      else chk("chip", exp_q.pop_front(), out_chip);
    end
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'h0);
    chk("ctrl", 0, rd_d);
    rd(4'h4);
    chk("length", 0, rd_d);
    rd(4'hc);
    chk("badresp", opsfc_pkg::RESP_SLVERR, rd_r);
    $display("test registers done");
    for (int i = 0; i < 16; i++)
      frame({2'h0, i[3:0], 4'h1}, 8);
    $display("test whitening done");
    frame(10'h083, 16);
    $display("test multiplexed done");
    frame(10'h005, 176);
    frame(10'h00d, 176);
    $display("test coded done");
    give_verdict();
  end
endmodule : tb_oqpsk_psdu_spread_fec_chain
